// ===== rtl/ssw_supervisor.sv
// Supply supervisor with reset hold, power-fail warning, RAM gating and watchdog.
// Summary of operation
// RULE_01: Reset held low while supply is low.
// RULE_02: Reset stays low for hold time after recovery.
// RULE_03: Hold time counts the selected timebase.
// RULE_04: Active-high reset mirrors the active-low reset.
// RULE_05: Sense input below reference drives warning low.
// RULE_06: Good supply passes RAM chip-select through.
// RULE_07: Low supply forces RAM chip-select high.
// RULE_08: Host toggles service input within timeout.
// RULE_09: Missed service gives a reset pulse.
// RULE_10: Pulses repeat each timeout until serviced.
// RULE_11: Expired output low until next service edge.
// RULE_12: Floating service input disables the watchdog.
// RULE_13: Watchdog timeout counts the selected timebase.
// RULE_14: Backup status low unless running from battery.
// RULE_15: Battery mode forces fixed outputs, ignores inputs.
// RULE_16: Either service edge restarts the timeout.
`timescale 1ns/1ps
module ssw_supervisor
#(
    parameter int HOLD_TICKS = ssw_pkg::HOLD_SHORT_CYC, // Reset hold; HOLD_LONG_CYC for the long variant.
    parameter int WD_TICKS   = ssw_pkg::WD_TIMEOUT_CYC  // Watchdog timeout in timebase ticks.
)
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic srst,
    // Comparator results.
    input  wire logic supply_low,       // High while the supply is below the reset threshold.
    input  wire logic supply_sense_in,  // High while the power-fail sense input is below reference.
    input  wire logic on_battery,       // High while the battery is above the main supply.
    // Host side inputs.
    input  wire logic watchdog_service_in,
    input  wire logic watchdog_float,   // High while the service pin is left floating.
    input  wire logic ram_cs_in_n,
    // Timebase pins.
    input  wire logic timebase_in,
    input  wire logic timebase_select,
    // Outputs.
    output logic      reset_n,
    output logic      reset_out,
    output logic      early_fail_warn_n,
    output logic      ram_cs_out_n,
    output logic      watchdog_expired_n,
    output logic      backup_status_out
);
    localparam logic [ssw_pkg::CNT_W-1:0] HOLD_LOAD = ssw_pkg::CNT_W'(HOLD_TICKS);
    localparam logic [ssw_pkg::CNT_W-1:0] WD_LAST   = ssw_pkg::CNT_W'(WD_TICKS - 1);
    localparam logic [ssw_pkg::CNT_W-1:0] CNT_ZERO  = '0;

    ssw_tick_if tb (); // Timebase link to the tick generator.

    // Tick generator for both the reset hold and the watchdog.
    ssw_timebase u_timebase
    (
        .core_clk    (core_clk),
        .srst        (srst),
        .timebase_in (timebase_in),
        .tb          (tb)
    );
    assign tb.select = timebase_select;

    // State registers.
    logic [ssw_pkg::CNT_W-1:0] hold_cnt_reg;  // Remaining reset hold after supply recovery.
    logic [ssw_pkg::CNT_W-1:0] pulse_cnt_reg; // Remaining watchdog reset pulse.
    logic [ssw_pkg::CNT_W-1:0] wd_cnt_reg;    // Ticks since the last service edge or timeout.
    ssw_pkg::ssw_wd_state_t    wd_state_reg;  // Watchdog armed or off.
    logic                      svc_prev_reg;  // Previous service input level.
    logic                      expired_reg;   // Watchdog has timed out since last service.

    // Decodes.
    wire supply_bad  = supply_low | on_battery;                             // Battery mode counts as bad supply.
    wire svc_edge    = (watchdog_service_in ^ svc_prev_reg) & ~on_battery; // RULE_16 RULE_15
    wire hold_busy   = (hold_cnt_reg != CNT_ZERO);
    wire pulse_busy  = (pulse_cnt_reg != CNT_ZERO);
    wire wd_allowed  = ~watchdog_float & ~supply_bad & ~hold_busy;          // RULE_12
    // A timeout only counts while the watchdog is allowed. A pin that floats in the very cycle of expiry
    // therefore starts no pulse. A service edge in that cycle wins, because the edge is what ends expiry.
    wire wd_timeout  = (wd_state_reg == ssw_pkg::WD_RUN) & wd_allowed & ~svc_edge & tb.tick
                     & (wd_cnt_reg == WD_LAST);                             // RULE_12 RULE_16
    // The timeout joins in so that reset falls in the same cycle as the expired output.
    wire reset_next  = supply_bad | hold_busy | pulse_busy | wd_timeout;    // RULE_01 RULE_02 RULE_09

    // Output next values.
    wire reset_n_next = ~reset_next;
    wire warn_n_next  = ~(supply_sense_in | on_battery);                   // RULE_05 RULE_15
    wire cs_n_next    = supply_bad ? 1'h1 : ram_cs_in_n;                   // RULE_06 RULE_07 RULE_15
    wire wdo_n_next   = ~(expired_reg | wd_timeout) | svc_edge | ~wd_allowed; // RULE_11

    // Power-on hold: reload while the supply is bad, then count the timebase down.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            hold_cnt_reg <= HOLD_LOAD;
        else if (supply_bad)
            hold_cnt_reg <= HOLD_LOAD;                     // RULE_01
        else if (hold_busy && tb.tick)
            hold_cnt_reg <= hold_cnt_reg - 1'h1;           // RULE_02 RULE_03
    end

    // Watchdog reset pulse; a running pulse completes even if service resumes.
    always_ff @(posedge core_clk)
    begin
        if (srst || supply_bad)
            pulse_cnt_reg <= CNT_ZERO;
        else if (wd_timeout)
            pulse_cnt_reg <= HOLD_LOAD;                    // RULE_09
        else if (pulse_busy && tb.tick)
            pulse_cnt_reg <= pulse_cnt_reg - 1'h1;
    end

    // Watchdog state and timeout count.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wd_state_reg <= ssw_pkg::WD_OFF;
            wd_cnt_reg   <= CNT_ZERO;
            expired_reg  <= 1'h0;
        end
        else
        begin
            case (wd_state_reg)
                ssw_pkg::WD_OFF:
                begin
                    // Disabled: the timeout count is held at zero and the expired flag is cleared.
                    wd_cnt_reg  <= CNT_ZERO;
                    expired_reg <= 1'h0;
                    if (wd_allowed)
                        wd_state_reg <= ssw_pkg::WD_RUN;
                end
                ssw_pkg::WD_RUN:
                begin
                    if (!wd_allowed)
                    begin
                        wd_state_reg <= ssw_pkg::WD_OFF;        // RULE_12
                        wd_cnt_reg   <= CNT_ZERO;
                        expired_reg  <= 1'h0;
                    end
                    else if (svc_edge)
                    begin
                        wd_cnt_reg  <= CNT_ZERO;                 // RULE_16
                        expired_reg <= 1'h0;                     // RULE_11
                    end
                    else if (wd_timeout)
                    begin
                        // Restart the count so a new pulse follows one timeout later.
                        wd_cnt_reg  <= CNT_ZERO;                 // RULE_10
                        expired_reg <= 1'h1;                     // RULE_11
                    end
                    else if (tb.tick)
                        wd_cnt_reg <= wd_cnt_reg + 1'h1;         // RULE_13
                end
                default:
                    wd_state_reg <= ssw_pkg::WD_OFF;
            endcase
        end
    end

    // Output flip-flops; every output is defined from reset on.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            svc_prev_reg       <= 1'h0;
            reset_n            <= 1'h0;
            reset_out          <= 1'h1;
            early_fail_warn_n  <= 1'h1;
            ram_cs_out_n       <= 1'h1;
            watchdog_expired_n <= 1'h1;
            backup_status_out  <= 1'h0;
        end
        else
        begin
            svc_prev_reg       <= watchdog_service_in;
            reset_n            <= reset_n_next;
            reset_out          <= reset_next;                // RULE_04
            early_fail_warn_n  <= warn_n_next;
            ram_cs_out_n       <= cs_n_next;
            watchdog_expired_n <= wdo_n_next;
            backup_status_out  <= on_battery;                // RULE_14
        end
    end

    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence batt_outputs_s;
        !reset_n && !early_fail_warn_n && watchdog_expired_n && ram_cs_out_n;
    endsequence

    sequence wd_fire_s;
        wd_timeout ##1 (!watchdog_expired_n && !reset_n);
    endsequence

    low_reset_a:    assert property (supply_low |=> !reset_n && reset_out)                   // RULE_01
        else $error("Reset not held during low supply.");
    hold_reset_a:   assert property (!supply_bad && hold_busy |=> !reset_n)                  // RULE_02
        else $error("Reset released before hold ended.");
    reset_inv_a:    assert property (reset_out == !reset_n)                                  // RULE_04
        else $error("Reset outputs disagree.");
    warn_low_a:     assert property (supply_sense_in |=> !early_fail_warn_n)                 // RULE_05
        else $error("Warning not raised.");
    cs_pass_a:      assert property (!supply_bad |=> ram_cs_out_n == $past(ram_cs_in_n))     // RULE_06
        else $error("Chip-select not passed through.");
    cs_block_a:     assert property (supply_low |=> ram_cs_out_n)                            // RULE_07
        else $error("Chip-select not blocked.");
    wd_fire_a:      assert property (wd_timeout && wd_allowed |-> wd_fire_s)                 // RULE_09
        else $error("Timeout gave no reset pulse.");
    wd_repeat_a:    assert property (wd_timeout && wd_allowed |=> wd_cnt_reg == CNT_ZERO)    // RULE_10
        else $error("Timeout count not restarted.");
    wd_stay_a:      assert property (expired_reg && wd_allowed && !svc_edge && $stable(wd_allowed)
                                     |=> !watchdog_expired_n)                                // RULE_11
        else $error("Expired output released without service.");
    wd_float_a:     assert property (watchdog_float |=> watchdog_expired_n && !pulse_busy
                                     || $past(pulse_busy))                                   // RULE_12
        else $error("Watchdog active while floating.");
    backup_a:       assert property (backup_status_out == $past(on_battery))                 // RULE_14
        else $error("Backup status wrong.");
    batt_mode_a:    assert property (on_battery |=> batt_outputs_s)                          // RULE_15
        else $error("Battery mode outputs wrong.");
    svc_restart_a:  assert property (svc_edge && wd_state_reg == ssw_pkg::WD_RUN && wd_allowed
                                     |=> wd_cnt_reg == CNT_ZERO && watchdog_expired_n)       // RULE_16
        else $error("Service edge did not restart the count.");
endmodule // ssw_supervisor

// ===== rtl/ssw_pkg.sv
// Shared constants and types for the supply supervisor and watchdog.
package ssw_pkg;
    // Core clock period in nanoseconds (10 MHz).
    localparam longint CLK_PERIOD_NS = 100;
    // Reset hold after supply recovery, standard and long variants, in nanoseconds.
    localparam longint HOLD_SHORT_NS = 50_000_000;
    localparam longint HOLD_LONG_NS  = 200_000_000;
    // Watchdog timeout with the internal timebase, in nanoseconds.
    localparam longint WD_TIMEOUT_NS = 1_600_000_000;
    // Cycle counts derived from the times; least times round up.
    localparam int HOLD_SHORT_CYC = int'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int HOLD_LONG_CYC  = int'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int WD_TIMEOUT_CYC = int'((WD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Width of the tick counters; holds the largest default count.
    localparam int CNT_W = 25;
    // Timebase select level that picks the internal oscillator.
    localparam logic SEL_INTERNAL = 1'h1;
    // Watchdog states.
    typedef enum logic [1:0]
    {
        WD_OFF = 2'b00,
        WD_RUN = 2'b01
    } ssw_wd_state_t;
endpackage

// ===== rtl/ssw_tick_if.sv
// Timebase carrier between the supervisor core and its tick generator.
`timescale 1ns/1ps
interface ssw_tick_if;
    logic select; // High picks the internal oscillator.
    logic tick;   // One-cycle timebase step.
    modport src (input select, output tick);
    modport snk (output select, input tick);
endinterface // ssw_tick_if

// ===== rtl/ssw_timebase.sv
// Timebase tick generator: internal oscillator or an external oscillator pin.
`timescale 1ns/1ps
module ssw_timebase
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic srst,
    // External oscillator or capacitor-set oscillator pin.
    input  wire logic timebase_in,
    // Tick towards the core.
    ssw_tick_if.src   tb
);
    // The external oscillator is free-running and unrelated to core_clk, so it is synchronised.
    logic sync1_reg; // First stage; read only by the second stage.
    logic sync2_reg; // Second stage, safe to use.
    logic prev_reg;  // Previous synchronised level for edge detection.
    wire  ext_rise;  // Rising edge of the external timebase.

    // Synchroniser and edge history.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync1_reg <= 1'h0;
            sync2_reg <= 1'h0;
            prev_reg  <= 1'h0;
        end
        else
        begin
            sync1_reg <= timebase_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign ext_rise = sync2_reg & ~prev_reg;
    // The internal oscillator steps every core cycle; an external source steps per rising edge.
    assign tb.tick  = (tb.select == ssw_pkg::SEL_INTERNAL) ? 1'h1 : ext_rise; // RULE_03 RULE_13
endmodule // ssw_timebase

// ===== dv/ssw_host_model.sv
// Host processor model that services the watchdog line.
`timescale 1ns/1ps
module ssw_host_model
#(
    parameter int PERIOD = 30 // Cycles between service edges; kept below the timeout.
)
(
    // Clock.
    input  wire logic core_clk,
    // Control from the bench.
    input  wire logic run,
    // Service line towards the supervisor.
    output logic      watchdog_service_in
);
    logic svc_level = 1'h0; // Service line level; starts low and idle.
    int   cnt       = 0;    // Cycles since the last service edge.
    // Edges land on the falling clock so the core always samples a settled level.
    always @(negedge core_clk)
    begin
        if (run && cnt >= PERIOD - 1)
        begin
            svc_level <= ~svc_level;
            cnt <= 0;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
    // A single process owns the line, so it has one driver.
    assign watchdog_service_in = svc_level;
endmodule // ssw_host_model

// ===== dv/supply_supervisor_watchdog_test.sv
// Self-checking bench for the supply supervisor and watchdog.
`timescale 1ns/1ps
module supply_supervisor_watchdog_test;
    localparam int H = 20;  // Reset hold ticks used in simulation.
    localparam int W = 100; // Watchdog timeout ticks used in simulation.
    localparam int P = 60;  // Host service period; above W/2, so only both edges together keep the watchdog fed.
    logic core_clk = 1'h0, srst = 1'h1, supply_low = 1'h0, supply_sense_in = 1'h0;
    logic on_battery = 1'h0, watchdog_float = 1'h0, ram_cs_in_n = 1'h1;
    logic timebase_in = 1'h0, timebase_select = 1'h1, host_run = 1'h1;
    logic watchdog_service_in, reset_n, reset_out, early_fail_warn_n;
    logic ram_cs_out_n, watchdog_expired_n, backup_status_out;
    int   failures = 0, n_checks = 0, n;
    // Core clock at 10 MHz; the external timebase ticks every four core cycles.
    always #50 core_clk = ~core_clk;
    always #200 timebase_in = ~timebase_in;
    ssw_host_model #(.PERIOD(P)) host (.core_clk(core_clk), .run(host_run),
        .watchdog_service_in(watchdog_service_in));
    ssw_supervisor #(.HOLD_TICKS(H), .WD_TICKS(W)) dut (.core_clk(core_clk), .srst(srst),
        .supply_low(supply_low), .supply_sense_in(supply_sense_in), .on_battery(on_battery),
        .watchdog_service_in(watchdog_service_in), .watchdog_float(watchdog_float),
        .ram_cs_in_n(ram_cs_in_n), .timebase_in(timebase_in), .timebase_select(timebase_select),
        .reset_n(reset_n), .reset_out(reset_out), .early_fail_warn_n(early_fail_warn_n),
        .ram_cs_out_n(ram_cs_out_n), .watchdog_expired_n(watchdog_expired_n),
        .backup_status_out(backup_status_out));
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Compares one seen value with its expectation.
    task automatic check(input string what, input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask
    // Waits for reset_n (s=0) or the expiry output (s=1) to reach v; a spent bound ends the run.
    task automatic wait_for(input int s, input logic v, input int lim, output int c);
        c = 0;
        while ((s ? watchdog_expired_n : reset_n) !== v && c < lim)
        begin
            @(negedge core_clk);
            c++;
        end
        if (c >= lim)
        begin
            failures++;
            summarize();
        end
    endtask
    // Supply drops and recovers; chip-select gating follows the supply state.
    task automatic t_supply();
        wait_for(0, 1'h1, 200, n);
        check("hold", n <= H + 3, 1'h1);
        ram_cs_in_n = 1'h0;
        repeat (2) @(negedge core_clk);
        check("cs pass", ram_cs_out_n, 1'h0);
        supply_low = 1'h1;
        repeat (50) @(negedge core_clk);
        check("rst low", reset_n, 1'h0);
        check("rst high", reset_out, 1'h1);
        check("cs gate", ram_cs_out_n, 1'h1);
        supply_low = 1'h0;
        wait_for(0, 1'h1, 200, n);
        check("hold len", n >= H && n <= H + 3, 1'h1);
        check("rst inv", reset_out, 1'h0);
        ram_cs_in_n = 1'h1;
        supply_sense_in = 1'h1;
        repeat (2) @(negedge core_clk);
        check("warn", early_fail_warn_n, 1'h0);
        supply_sense_in = 1'h0;
        repeat (2) @(negedge core_clk);
        check("warn off", early_fail_warn_n, 1'h1);
        $display("test supply done");
    endtask
    // Missed service gives repeated pulses and a held expiry flag.
    task automatic t_wdog();
        repeat (3 * W) @(negedge core_clk);
        check("serviced", watchdog_expired_n, 1'h1);
        host_run = 1'h0;
        wait_for(1, 1'h0, W + P + 10, n);
        check("timeout", n >= W - P && n <= W + 3, 1'h1);
        @(negedge core_clk);
        check("wd pulse", reset_n, 1'h0);
        wait_for(0, 1'h1, 200, n);
        check("pulse len", n >= H - 2 && n <= H + 2, 1'h1);
        wait_for(0, 1'h0, W + 10, n);
        check("repeat", n >= W - H - 4 && n <= W - H + 2, 1'h1);
        check("wdo held", watchdog_expired_n, 1'h0);
        host_run = 1'h1;
        wait_for(1, 1'h1, P + 4, n);
        wait_for(0, 1'h1, 200, n);
        $display("test watchdog done");
    endtask
    // Floating service line and battery mode.
    task automatic t_modes();
        watchdog_float = 1'h1;
        host_run = 1'h0;
        repeat (3 * W) @(negedge core_clk);
        check("float wdo", watchdog_expired_n, 1'h1);
        check("float rst", reset_n, 1'h1);
        watchdog_float = 1'h0;
        host_run = 1'h1;
        on_battery = 1'h1;
        ram_cs_in_n = 1'h0;
        repeat (2) @(negedge core_clk);
        check("bat rst", reset_n, 1'h0);
        check("bat warn", early_fail_warn_n, 1'h0);
        check("bat wdo", watchdog_expired_n, 1'h1);
        check("bat cs", ram_cs_out_n, 1'h1);
        check("bat on", backup_status_out, 1'h1);
        on_battery = 1'h0;
        ram_cs_in_n = 1'h1;
        repeat (2) @(negedge core_clk);
        check("bat off", backup_status_out, 1'h0);
        wait_for(0, 1'h1, 200, n);
        $display("test modes done");
    endtask
    // External timebase stretches both the hold and the timeout.
    task automatic t_ext();
        timebase_select = 1'h0;
        supply_low = 1'h1;
        repeat (2) @(negedge core_clk);
        supply_low = 1'h0;
        wait_for(0, 1'h1, 8 * H, n);
        check("ext hold", n >= 4 * H - 8 && n <= 4 * H + 12, 1'h1);
        host_run = 1'h0;
        wait_for(1, 1'h0, 4 * W + P + 20, n);
        check("ext wd", n >= 4 * W - P - 8, 1'h1);
        host_run = 1'h1;
        wait_for(1, 1'h1, P + 4, n);
        wait_for(0, 1'h1, 8 * H, n);
        timebase_select = 1'h1;
        $display("test timebase done");
    endtask
    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial
    begin
        repeat (16) @(negedge core_clk);
        srst = 1'h0;
        t_supply();
        t_wdog();
        t_modes();
        t_ext();
        summarize();
    end
endmodule // supply_supervisor_watchdog_test
